/* rtl/aspm_pkg.sv */
// Package of constants and carrier types for the converter serial mode control.
package aspm_pkg;
   localparam int unsigned FRAME_BITS     = 16;
   localparam int unsigned RESULT_BITS    = 12;
   localparam logic [4:0]  EDGE_GLITCH    = 5'h02;
   localparam logic [4:0]  EDGE_KEEP_PWR  = 5'h0A;
   localparam logic [4:0]  EDGE_TRACK     = 5'h0D;
   localparam logic [4:0]  EDGE_LAST      = 5'h10;
   localparam logic [4:0]  EDGE_CNT_RESET = 5'h00;
   localparam logic [15:0] FRAME_RESET    = 16'h0000;
   localparam logic        PWR_UP_RESET   = 1'b1;
   localparam logic        TRACK_RESET    = 1'b1;
   localparam int unsigned QUIET_NS       = 25;
   localparam int unsigned SYS_PERIOD_NS  = 100;
   localparam int unsigned QUIET_CYCLES   = (QUIET_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

   typedef enum logic [1:0] {
      ASPM_IDLE   = 2'b00,
      ASPM_FRAME  = 2'b01,
      ASPM_DONE   = 2'b10
   } aspm_state_type;

   typedef struct packed {
      logic powered;
      logic tracking;
   } aspm_status_type;
endpackage

/* rtl/aspm_ctrl.sv */
// Chip-select and serial-clock driven mode control of a 12-bit sampling converter.
//
// Functional notes
// - Sample and start conversion at select fall.
// - Rise after edge 10: stay powered, abort.
// - Full frame is sixteen clocks; clock idles either.
// - Rise after edges 2..9: power down, abort.
// - Power-down switches all analog circuitry off.
// - Rise before edge 2 keeps normal mode.
// - Dummy past edge 10 wakes device up.
// - Asleep and early rise: back to power-down.
// - One dummy cycle suffices up to 18 MHz.
// - On wake, hold until first clock edge.
// - Device may start in either mode; reset here always starts it powered.
// - Track/hold starts in track after power-up.
// - Select fall gives first zero; edges shift.
// - Output released at sixteenth falling edge.
// - Track again at rise after edge 13.
`timescale 1ns/1ps
module aspm_ctrl (
   input  wire logic                  clk_sys,
   input  wire logic                  rstn,
   input  wire logic                  sclk_link,
   input  wire logic                  cs_n,
   input  wire logic [11:0]           adc_result,
   output logic                       serial_result_out,
   output logic                       serial_result_oe,
   output logic                       analog_powered,
   output logic                       track_mode,
   output logic                       conv_done,
   output aspm_pkg::aspm_status_type  status
);
   import aspm_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Limitations. The select and the serial clock both come from the host, so
   // the frame logic takes the select edges as asynchronous events. The power
   // decision reads the edge count at the select rise that also clears it; the
   // host's quiet time around the last clock edge keeps that count settled.
   // The data pin enable has to rise at the select fall before any clock edge,
   // so it is decoded from the select and a flop rather than registered.
   // The status outputs lag the link by a few system cycles; software that
   // needs the exact instant of a mode change must watch the frame-end pulse.

   ////////////////////////////////////////////////////////////////////////////
   // Decoding of the falling-edge count, shared by the power decision and the
   // track/hold control.

   // A select rise in this window of edges sends the device to power-down.
   function automatic logic in_sleep_window(input logic [4:0] cnt);
      logic hit;
      hit = (cnt >= EDGE_GLITCH) && (cnt < EDGE_KEEP_PWR);
      in_sleep_window = hit;
   endfunction

   // A select rise this early is taken as a glitch and changes no mode.
   function automatic logic in_glitch_window(input logic [4:0] cnt);
      logic hit;
      hit = (cnt < EDGE_GLITCH);
      in_glitch_window = hit;
   endfunction

   // A select rise this late keeps or brings the device powered.
   function automatic logic in_keep_window(input logic [4:0] cnt);
      in_keep_window = (cnt >= EDGE_KEEP_PWR);
   endfunction

   // Mode kept after a select rise; an asleep device only wakes from a frame
   // that reached the keep window, so a short burst of clocks cannot wake it.
   function automatic logic mode_after_rise(input logic [4:0] cnt,
                                            input logic       was_asleep);
      logic keep;
      keep = 1'b0;
      if (in_keep_window(cnt)) begin
         keep = 1'b1;
      end else if (in_glitch_window(cnt)) begin
         keep = ~was_asleep;
      end else if (in_sleep_window(cnt)) begin
         keep = 1'b0;
      end
      mode_after_rise = keep;
   endfunction

   // Track/hold state inside a frame. A wake frame tracks from its first
   // clock edge of either sense; a normal frame only after the conversion
   // has taken what it needs from the held sample.
   function automatic logic track_in_frame(input logic wake,
                                           input logic wake_edge,
                                           input logic late_edge);
      track_in_frame = wake ? wake_edge : late_edge;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Link domain. Select high clears the frame logic, which ends a cut frame
   // by the frame's own signal, with no clock needed, whatever the host does
   // with its clock afterwards.

   logic [4:0]     edge_cnt;
   logic [15:0]    shift_reg;
   aspm_state_type frame_state;
   aspm_state_type next_frame_state;
   logic           first_rise;
   logic           late_track;
   logic           wake_frame;
   logic           powered_link;
   logic           done_tgl;
   logic           track_link;
   logic           powered_raw;

   wire [15:0] frame_word    = {4'h0, adc_result};
   wire        cnt_start     = (edge_cnt == EDGE_CNT_RESET);
   wire        cnt_full      = (edge_cnt == EDGE_LAST);
   wire [4:0]  next_edge_cnt = cnt_full ? edge_cnt : edge_cnt + 5'h01;
   wire        late_edge     = (edge_cnt >= EDGE_TRACK);
   wire        wake_edge     = ~cnt_start | first_rise;
   wire        frame_live    = (frame_state != ASPM_DONE);

   // Next value of the shift register: the first edge loads the frame less
   // its first zero, which already stands; later edges move one place.
   wire [15:0] next_shift;
   assign next_shift[0] = 1'b0;
   genvar b;
   generate
      for (b = 1; b < FRAME_BITS; b++) begin : g_shift
         assign next_shift[b] = cnt_start ? frame_word[b-1] : shift_reg[b-1];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Frame sequencer: the sixteenth falling edge ends the frame and releases
   // the data pin even while the select stays low.
   always_comb begin
      next_frame_state = frame_state;
      case (frame_state)
         ASPM_IDLE: begin
            next_frame_state = ASPM_FRAME;
         end
         ASPM_FRAME: begin
            if (next_edge_cnt == EDGE_LAST) begin
               next_frame_state = ASPM_DONE;
            end
         end
         ASPM_DONE: begin
            next_frame_state = ASPM_DONE;
         end
         default: begin
            // An unused code falls back to the start of a frame; the next
            // select rise clears it in any case.
            next_frame_state = ASPM_IDLE;
         end
      endcase
   end

   always_ff @(negedge sclk_link or posedge cs_n) begin
      if (cs_n) begin
         frame_state <= ASPM_IDLE;
      end else begin
         frame_state <= next_frame_state;
      end
   end

   always_ff @(negedge sclk_link or posedge cs_n) begin
      if (cs_n) begin
         edge_cnt <= EDGE_CNT_RESET;
      end else begin
         edge_cnt <= next_edge_cnt;
      end
   end

   // The register stands at zero outside a frame, so its top bit is the first
   // leading zero from the select fall on; each falling edge moves one bit.
   always_ff @(negedge sclk_link or posedge cs_n) begin
      if (cs_n) begin
         shift_reg <= FRAME_RESET;
      end else begin
         shift_reg <= next_shift;
      end
   end

   // Marks a rising clock edge in this frame, for a host whose clock idles low.
   always_ff @(posedge sclk_link or posedge cs_n) begin
      if (cs_n) begin
         first_rise <= 1'b0;
      end else begin
         first_rise <= 1'b1;
      end
   end

   // Track again at the rising edge that follows the thirteenth falling edge.
   always_ff @(posedge sclk_link or posedge cs_n) begin
      if (cs_n) begin
         late_track <= 1'b0;
      end else begin
         late_track <= late_edge;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // The frame type is caught at the select fall, where power-up starts.
   always_ff @(negedge cs_n or negedge rstn) begin
      if (!rstn) begin
         wake_frame <= 1'b0;
      end else begin
         wake_frame <= ~powered_link;
      end
   end

   // The power decision reads the edge count as it stood before the same
   // select rise clears it.
   always_ff @(posedge cs_n or negedge rstn) begin
      if (!rstn) begin
         powered_link <= PWR_UP_RESET;
      end else begin
         powered_link <= mode_after_rise(edge_cnt, wake_frame);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Each select rise toggles this flag, which tells the system side that a
   // frame has ended without passing a pulse across the clock boundary.
   always_ff @(posedge cs_n or negedge rstn) begin
      if (!rstn) begin
         done_tgl <= 1'b0;
      end else begin
         done_tgl <= ~done_tgl;
      end
   end

   // Powered while the select is low too: a wake frame starts power-up at the
   // fall, and an asleep device drops back at an early rise.
   assign powered_raw = powered_link | ~cs_n;

   // Hold from the select fall. Outside frames the track/hold tracks while
   // powered and holds while asleep; power-up leaves it in track, so no
   // dummy frame is needed for that.
   assign track_link = cs_n ? powered_link
                            : track_in_frame(wake_frame, wake_edge, late_track);

   ////////////////////////////////////////////////////////////////////////////
   // Data pin pair. The data bit comes straight from the shift register; the
   // enable drops at the select rise or at the end of the frame.
   assign serial_result_out = shift_reg[15];
   assign serial_result_oe  = ~cs_n & frame_live;

   ////////////////////////////////////////////////////////////////////////////
   // System domain. Every signal from the link side passes two flops before
   // any logic reads it; only the second flop of each pair is read.

   localparam int unsigned N_SYNC     = 3;
   localparam logic [2:0]  SYNC_RESET = {1'b0, TRACK_RESET, PWR_UP_RESET};

   logic [N_SYNC-1:0] sync_in;
   logic [N_SYNC-1:0] sync_q1;
   logic [N_SYNC-1:0] sync_q2;
   logic              done_seen;
   logic              done_pulse;
   logic              powered_out;
   logic              track_out;
   aspm_status_type   status_out;

   // Bit 0 is the power state, bit 1 the track/hold, bit 2 the frame toggle.
   assign sync_in = {done_tgl, track_link, powered_raw};

   // The power and track bits are single levels that move seldom, so a plain
   // two-flop pair is enough; a bit caught a cycle late costs only latency.
   // The frame end crosses as a toggle for the same reason: a level change
   // cannot be lost, whereas a short pulse could fall between two edges.
   genvar g;
   generate
      for (g = 0; g < N_SYNC; g++) begin : g_sync
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               sync_q1[g] <= SYNC_RESET[g];
            end else begin
               sync_q1[g] <= sync_in[g];
            end
         end

         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               sync_q2[g] <= SYNC_RESET[g];
            end else begin
               sync_q2[g] <= sync_q1[g];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // A change of the toggle marks a frame end; the extra flop keeps the last
   // synchronised value so the pulse lasts exactly one cycle.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         done_seen <= 1'b0;
      end else begin
         done_seen <= sync_q2[2];
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         done_pulse <= 1'b0;
      end else begin
         done_pulse <= sync_q2[2] ^ done_seen;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output stage: the status outputs are registered once more so that all
   // of them change in the same cycle and straight from flops.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         powered_out <= PWR_UP_RESET;
      end else begin
         powered_out <= sync_q2[0];
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         track_out <= TRACK_RESET;
      end else begin
         track_out <= sync_q2[1];
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         status_out <= '{powered: PWR_UP_RESET, tracking: TRACK_RESET};
      end else begin
         status_out <= '{powered: sync_q2[0], tracking: sync_q2[1]};
      end
   end

   assign analog_powered = powered_out;
   assign track_mode     = track_out;
   assign status         = status_out;
   assign conv_done      = done_pulse;
endmodule

/* test/aspm_ctrl_monitor.sv */
// Checker of the converter mode control ports.
`timescale 1ns/1ps
module aspm_ctrl_monitor (
   input wire logic        clk_sys,
   input wire logic        rstn,
   input wire logic        cs_n,
   input wire logic        serial_result_out,
   input wire logic        serial_result_oe,
   input wire logic        analog_powered,
   input wire logic        track_mode,
   input wire logic        conv_done,
   input wire aspm_pkg::aspm_status_type status
);
   import aspm_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence sel_idle; cs_n [*3]; endsequence
   sequence sel_rise; $rose(cs_n); endsequence
   chk_oe_idle: assert property (sel_idle |-> !serial_result_oe)
      else $error("data pin driven while idle");
   chk_rise_done: assert property (sel_rise |-> ##[1:6] conv_done)
      else $error("no frame end pulse");
   chk_done_pulse: assert property (conv_done |=> !conv_done)
      else $error("frame end pulse too long");
   chk_done_sel: assert property (conv_done |-> cs_n)
      else $error("frame end with select low");
   chk_power_sel: assert property ($fell(analog_powered) |-> cs_n)
      else $error("power dropped in a frame");
   chk_oe_start: assert property ($rose(serial_result_oe) |-> !cs_n)
      else $error("data pin driven without select");
   chk_lead_zero: assert property ($rose(serial_result_oe) |-> !serial_result_out)
      else $error("first bit not zero");
   chk_status_map: assert property (status == {analog_powered, track_mode})
      else $error("status differs from outputs");
endmodule
bind aspm_ctrl aspm_ctrl_monitor aspm_ctrl_monitor_i (.clk_sys(clk_sys), .rstn(rstn),
   .cs_n(cs_n), .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
   .analog_powered(analog_powered), .track_mode(track_mode), .conv_done(conv_done),
   .status(status));

/* test/aspm_host_model.sv */
// Host serial port model that frames conversions on the link.
`timescale 1ns/1ps
module aspm_host_model (
   output logic        cs_n,
   output logic        sclk_link,
   input  wire logic   serial_result_out,
   input  wire logic   serial_result_oe,
   output logic [15:0] got
);
   initial begin
      cs_n = 1'b1;
      sclk_link = 1'b1;
      got = 16'h0000;
   end
   // The clock stands high between frames; a bit is read just before the edge that moves it.
   task automatic run(input int n);
      cs_n = 1'b0;
      #80;
      for (int i = 0; i < n; i++) begin
         got = {got[14:0], serial_result_oe ? serial_result_out : 1'bx};
         sclk_link = 1'b0;
         #80;
         sclk_link = 1'b1;
         #80;
      end
      cs_n = 1'b1;
      #30;
   endtask
endmodule

/* test/testbench.sv */
// Self-checking bench of the converter mode control.
`timescale 1ns/1ps
module testbench;
   import aspm_pkg::*;
   logic clk_sys, rstn, sclk_link, cs_n, serial_result_out, serial_result_oe;
   logic analog_powered, track_mode, conv_done;
   logic [11:0] adc_result;
   logic [15:0] got;
   aspm_status_type status;
   int failures, n_checks;
   aspm_ctrl aspm_ctrl_i (.clk_sys(clk_sys), .rstn(rstn), .sclk_link(sclk_link), .cs_n(cs_n),
      .adc_result(adc_result), .serial_result_out(serial_result_out),
      .serial_result_oe(serial_result_oe), .analog_powered(analog_powered),
      .track_mode(track_mode), .conv_done(conv_done), .status(status));
   aspm_host_model aspm_host_model_i (.cs_n(cs_n), .sclk_link(sclk_link), .got(got),
      .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe));
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic test_done();
      if (failures == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // The mode is judged only after the frame-end pulse, since it crosses from the link side.
   task automatic frame(input int n);
      int k;
      aspm_host_model_i.run(n);
      k = 0;
      while (conv_done !== 1'b1 && k < 40) begin
         @(negedge clk_sys);
         k++;
      end
      if (conv_done !== 1'b1) begin
         failures++;
         test_done();
      end
      repeat (3) @(negedge clk_sys);
   endtask
   task automatic t_full(input logic [11:0] v);
      adc_result = v;
      frame(16);
      chk("frame", got, {4'h0, v});
      chk("full", {13'h0000, analog_powered, track_mode, serial_result_oe}, 16'h0006);
   endtask
   task automatic t_mode(input int n, input logic [15:0] exp);
      frame(n);
      chk("mode", {13'h0000, analog_powered, track_mode, serial_result_oe}, exp);
   endtask
   initial begin
      rstn = 1'b0;
      adc_result = 12'hA5C;
      failures = 0;
      n_checks = 0;
      repeat (12) @(negedge clk_sys);
      rstn = 1'b1;
      @(negedge clk_sys);
      chk("start", {13'h0000, analog_powered, track_mode, serial_result_oe}, 16'h0006);
      t_full(12'hA5C);
      frame(1);
      chk("glitch", {14'h0000, analog_powered, serial_result_oe}, 16'h0002);
      t_mode(2, 16'h0000);
      t_mode(9, 16'h0000);
      t_mode(10, 16'h0006);
      t_full(12'h3F1);
      t_mode(12, 16'h0006);
      test_done();
   end
endmodule
